// File: core/drive_params.svh
`ifndef DRIVE_PARAMS_SVH
`define DRIVE_PARAMS_SVH

// Register byte addresses
`define ADDR_RAMP_SW_FREQ   8'h00
`define ADDR_REV_INHIBIT    8'h04
`define ADDR_STOP_METHOD    8'h08
`define ADDR_IN_FUNC_BASE   8'h0c
`define ADDR_INIT_MODE      8'h24
`define ADDR_MIN_BLOCK      8'h28
`define ADDR_RAMP_TIME_BASE 8'h2c
`define ADDR_STATUS         8'h4c

// Setting ranges and reset values
`define RAMP_SW_FREQ_MAX    13'hfa0
`define RAMP_SW_FREQ_RST    13'h000
`define RAMP_TIME_MAX       16'hea60
`define RAMP_TIME_RST       16'h0064
`define MIN_BLOCK_RST       16'h0005
`define INIT_3WIRE          16'h0d02
`define FUNC_CODE_MAX       7'h77

// Stop method codes
`define STOP_RAMP           2'h0
`define STOP_COAST          2'h1
`define STOP_DC             2'h2
`define STOP_COAST_TIMED    2'h3

// Input function codes
`define FUNC_3WIRE          7'h00
`define FUNC_STEP1          7'h03
`define FUNC_STEP2          7'h04
`define FUNC_STEP3          7'h05
`define FUNC_JOG_REF        7'h06
`define FUNC_RAMP_SEL1      7'h07
`define FUNC_RAMP_SEL2      7'h1a
`define FUNC_JOG_FWD        7'h12
`define FUNC_JOG_REV        7'h13
`define FUNC_FAST_NO        7'h15
`define FUNC_FAST_NC        7'h17
`define FUNC_ANALOG_SW      7'h1f

// Selector defaults, normal and after 3-wire initialisation
`define SEL_RST0            7'h24
`define SEL_RST1            7'h14
`define SEL_RST2            7'h03
`define SEL_RST3            7'h04
`define SEL_RST4            7'h06
`define SEL_RST5            7'h08
`define SEL_3W2             7'h00
`define SEL_3W3             7'h03
`define SEL_3W4             7'h04
`define SEL_3W5             7'h06

// Ramp pair indices (pair one to four)
`define PAIR_ONE            2'h0
`define PAIR_FOUR           2'h3

// Timing
`define TENTH_SEC_NS        100000000
`define CLK_PERIOD_NS       8

`endif

// File: core/drive_pkg.sv
`default_nettype none
`include "drive_params.svh"

package drive_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RUN,
		ST_RAMP,
		ST_COAST,
		ST_DC,
		ST_COAST_T
	} drive_state_t;

	typedef logic [6:0] func_code_t;

	function automatic logic wordAt(input logic [7:0] addr, input logic [7:0] base,
			input int idx);
		logic [7:0] off;
		off = 8'(idx * 4);
		return addr == 8'(base + off);
	endfunction : wordAt
endpackage : drive_pkg

`default_nettype wire

// File: core/ahb_lite_slave.sv
`default_nettype none

module ahb_lite_slave (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic [31:0] hrdata,
	output var  logic        hresp,
	output var  logic        regWrite,
	output var  logic [7:0]  regAddr,
	output var  logic [31:0] regWdata,
	input  wire logic [31:0] rdData
);
	logic       wrPend;
	logic       rdPend;
	logic       next_wrPend;
	logic       next_rdPend;
	logic       next_hreadyout;
	logic [7:0] next_regAddr;
	logic [31:0] next_hrdata;
	logic       addrPhase;

	// Only whole-word singles are issued; hsize is not checked
	always_comb begin
		addrPhase      = hsel & htrans[1] & hready;
		next_wrPend    = addrPhase & hwrite;
		next_rdPend    = addrPhase & ~hwrite;
		next_regAddr   = addrPhase ? haddr[7:0] : regAddr;
		// One wait state on reads so a write just committed is seen
		next_hreadyout = ~next_rdPend;
		next_hrdata    = rdPend ? rdData : hrdata;
		regWrite       = wrPend;
		regWdata       = hwdata;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wrPend    <= 1'b0;
			rdPend    <= 1'b0;
			regAddr   <= 8'h00;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			wrPend    <= next_wrPend;
			rdPend    <= next_rdPend;
			regAddr   <= next_regAddr;
			hreadyout <= next_hreadyout;
			hrdata    <= next_hrdata;
			hresp     <= 1'b0;
		end
	end
endmodule : ahb_lite_slave

`default_nettype wire

// File: core/lockout_timer.sv
`default_nettype none

module lockout_timer #(
	parameter int TICK_CYCLES = 12500000
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        start,
	input  wire logic [15:0] tenths,
	output var  logic        busy
);
	localparam int PW = $clog2(TICK_CYCLES + 1);

	if (TICK_CYCLES < 1) begin : badTick
		$error("lockout_timer needs TICK_CYCLES of at least one");
	end

	logic [PW-1:0] pre;
	logic [15:0]   remain;
	logic [PW-1:0] next_pre;
	logic [15:0]   next_remain;
	logic          next_busy;

	// Counts whole tenths of a second; a zero load still blocks one tick
	always_comb begin
		next_pre    = pre;
		next_remain = remain;
		next_busy   = busy;
		if (start) begin
			next_pre    = PW'(TICK_CYCLES - 1);
			next_remain = tenths;
			next_busy   = 1'b1;
		end else if (busy) begin
			if (pre == '0) begin
				next_pre = PW'(TICK_CYCLES - 1);
				if (remain <= 16'h0001) begin
					next_busy = 1'b0;
				end else begin
					next_remain = remain - 16'h0001;
				end
			end else begin
				next_pre = pre - PW'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pre    <= '0;
			remain <= 16'h0000;
			busy   <= 1'b0;
		end else begin
			pre    <= next_pre;
			remain <= next_remain;
			busy   <= next_busy;
		end
	end
endmodule : lockout_timer

`default_nettype wire

// File: core/drive_ramp_stop_input_select.sv
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
`include "drive_params.svh"

module drive_ramp_stop_input_select
	import drive_pkg::*;
#(
	parameter int TENTH_CYCLES = `TENTH_SEC_NS / `CLK_PERIOD_NS
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic [31:0] hrdata,
	output var  logic        hresp,
	input  wire logic [5:0]  termIn,
	input  wire logic        fwdRunIn,
	input  wire logic        revRunIn,
	input  wire logic        fluxVector,
	input  wire logic [12:0] outFreq,
	output var  logic [1:0]  rampPair,
	output var  logic [15:0] accelTime,
	output var  logic [15:0] decelTime,
	output var  logic        runFwd,
	output var  logic        runRev,
	output var  logic        rampDown,
	output var  logic        coasting,
	output var  logic        dcBrake,
	output var  logic        runIgnored,
	output var  logic        threeWire,
	output var  logic        revRejected,
	output var  logic        fastStop,
	output var  logic [2:0]  stepRef,
	output var  logic        jogRef,
	output var  logic        analogSel
);
	if (TENTH_CYCLES < 1) begin : badTenth
		$error("TENTH_CYCLES must be at least one");
	end

	logic        regWrite;
	logic [7:0]  regAddr;
	logic [31:0] regWdata;
	logic [31:0] rdData;

	ahb_lite_slave busSlave (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.regWrite  (regWrite),
		.regAddr   (regAddr),
		.regWdata  (regWdata),
		.rdData    (rdData)
	);

	// Settings
	logic [12:0]           swFreq;
	logic                  revInhibit;
	logic [1:0]            stopMethod;
	func_code_t [5:0]      inSel;
	logic [15:0]           initMode;
	logic [15:0]           minBlock;
	logic [7:0][15:0]      rampTime;
	logic [12:0]           next_swFreq;
	logic                  next_revInhibit;
	logic [1:0]            next_stopMethod;
	func_code_t [5:0]      next_inSel;
	logic [15:0]           next_initMode;
	logic [15:0]           next_minBlock;
	logic [7:0][15:0]      next_rampTime;

	// Sequencing state
	drive_state_t state;
	drive_state_t next_state;
	logic         dirRev;
	logic         next_dirRev;
	logic         latch3w;
	logic         next_latch3w;
	logic         fastHold;
	logic         next_fastHold;
	logic         timerStart;
	logic [15:0]  timerLoad;
	logic         timerBusy;
	logic         locked;

	function automatic logic anyOn(input func_code_t [5:0] s, input logic [5:0] t,
			input func_code_t code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 6; i++) begin
			r = r | ((s[i] == code) & t[i]);
		end
		return r;
	endfunction : anyOn

	function automatic logic isSet(input func_code_t [5:0] s, input func_code_t code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 6; i++) begin
			r = r | (s[i] == code);
		end
		return r;
	endfunction : isSet

	// Input decode
	logic       sel1;
	logic       sel2;
	logic       manualRamp;
	logic [1:0] pairNow;
	logic       is3w;
	logic       dirIn;
	logic       jogF;
	logic       jogR;
	logic       fastNow;
	logic       wantFwd;
	logic       wantRev;
	logic       rawRun;
	logic       runReq;
	logic       revBlock;

	always_comb begin
		sel1       = anyOn(inSel, termIn, `FUNC_RAMP_SEL1);
		sel2       = anyOn(inSel, termIn, `FUNC_RAMP_SEL2);
		manualRamp = isSet(inSel, `FUNC_RAMP_SEL1) | isSet(inSel, `FUNC_RAMP_SEL2);
		if (manualRamp) begin
			pairNow = {sel2, sel1};
		end else if (outFreq >= swFreq) begin
			pairNow = `PAIR_ONE;
		end else begin
			pairNow = `PAIR_FOUR;
		end
		is3w    = isSet(inSel, `FUNC_3WIRE);
		dirIn   = anyOn(inSel, termIn, `FUNC_3WIRE);
		jogF    = anyOn(inSel, termIn, `FUNC_JOG_FWD);
		jogR    = anyOn(inSel, termIn, `FUNC_JOG_REV);
		// Normally-closed fast stop acts when its terminal drops
		fastNow = anyOn(inSel, termIn, `FUNC_FAST_NO)
			| anyOn(inSel, ~termIn, `FUNC_FAST_NC);
		// 3-wire: run pulses latch, stop input is normally closed
		next_latch3w = is3w & revRunIn & (fwdRunIn | latch3w);
		if (is3w) begin
			wantFwd = (latch3w & ~dirIn) | (jogF & ~jogR);
			wantRev = (latch3w & dirIn) | (jogR & ~jogF);
		end else begin
			wantFwd = (fwdRunIn & ~revRunIn) | (jogF & ~jogR);
			wantRev = (revRunIn & ~fwdRunIn) | (jogR & ~jogF);
		end
		rawRun   = wantFwd | wantRev;
		revBlock = wantRev & ~wantFwd & revInhibit;
		// Fast stop clears only once the run command is removed too
		next_fastHold = (fastHold | fastNow) & (fastNow | rawRun);
		runReq = (wantFwd | (wantRev & ~revInhibit)) & ~fastHold & ~fastNow;
	end

	// Stop sequencing
	always_comb begin
		next_state  = state;
		next_dirRev = dirRev;
		timerStart  = 1'b0;
		timerLoad   = minBlock;
		case (state)
			ST_IDLE: begin
				if (runReq) begin
					next_state  = ST_RUN;
					next_dirRev = ~wantFwd;
				end
			end
			ST_RUN: begin
				if (fastNow | fastHold) begin
					next_state = ST_RAMP;
				end else if (!runReq) begin
					case (stopMethod)
						`STOP_RAMP: next_state = ST_RAMP;
						`STOP_COAST: begin
							next_state = ST_COAST;
							timerStart = 1'b1;
						end
						`STOP_DC: next_state = ST_DC;
						`STOP_COAST_TIMED: begin
							next_state = ST_COAST_T;
							timerStart = 1'b1;
							timerLoad  = rampTime[{pairNow, 1'b1}];
						end
						default: next_state = ST_RAMP;
					endcase
				end
			end
			ST_RAMP: begin
				if (outFreq == 13'h0000) begin
					next_state = ST_IDLE;
				end else if (runReq & ~fastHold) begin
					next_state  = ST_RUN;
					next_dirRev = ~wantFwd;
				end
			end
			ST_DC: begin
				if (outFreq == 13'h0000) begin
					next_state = ST_IDLE;
				end
			end
			ST_COAST, ST_COAST_T: begin
				if (!timerBusy) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	lockout_timer #(
		.TICK_CYCLES (TENTH_CYCLES)
	) blockTimer (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.start   (timerStart),
		.tenths  (timerLoad),
		.busy    (timerBusy)
	);

	// Register writes
	always_comb begin
		locked          = state != ST_IDLE;
		next_swFreq     = swFreq;
		next_revInhibit = revInhibit;
		next_stopMethod = stopMethod;
		next_inSel      = inSel;
		next_initMode   = initMode;
		next_minBlock   = minBlock;
		next_rampTime   = rampTime;
		if (regWrite && !locked) begin
			if (wordAt(regAddr, `ADDR_RAMP_SW_FREQ, 0)
					&& regWdata <= 32'(`RAMP_SW_FREQ_MAX)) begin
				next_swFreq = regWdata[12:0];
			end
			if (wordAt(regAddr, `ADDR_REV_INHIBIT, 0) && regWdata[31:1] == '0) begin
				next_revInhibit = regWdata[0];
			end
			if (wordAt(regAddr, `ADDR_STOP_METHOD, 0) && regWdata[31:2] == '0
					&& (!fluxVector || regWdata[1:0] <= `STOP_COAST)) begin
				next_stopMethod = regWdata[1:0];
			end
			for (int i = 0; i < 6; i++) begin
				if (wordAt(regAddr, `ADDR_IN_FUNC_BASE, i)
						&& regWdata <= 32'(`FUNC_CODE_MAX)) begin
					next_inSel[i] = regWdata[6:0];
				end
			end
			if (wordAt(regAddr, `ADDR_INIT_MODE, 0) && regWdata[31:16] == '0) begin
				next_initMode = regWdata[15:0];
				if (regWdata[15:0] == `INIT_3WIRE) begin
					next_inSel[2] = `SEL_3W2;
					next_inSel[3] = `SEL_3W3;
					next_inSel[4] = `SEL_3W4;
					next_inSel[5] = `SEL_3W5;
				end
			end
			if (wordAt(regAddr, `ADDR_MIN_BLOCK, 0) && regWdata[31:16] == '0) begin
				next_minBlock = regWdata[15:0];
			end
		end
		// Pairs one and two stay writable in operation, three and four do not
		for (int i = 0; i < 8; i++) begin
			if (regWrite && wordAt(regAddr, `ADDR_RAMP_TIME_BASE, i)
					&& regWdata <= 32'(`RAMP_TIME_MAX) && (i < 4 || !locked)) begin
				next_rampTime[i] = regWdata[15:0];
			end
		end
	end

	// Read decode; unmapped words read zero
	always_comb begin
		rdData = 32'h0000_0000;
		if (wordAt(regAddr, `ADDR_RAMP_SW_FREQ, 0)) rdData = 32'(swFreq);
		if (wordAt(regAddr, `ADDR_REV_INHIBIT, 0)) rdData = 32'(revInhibit);
		if (wordAt(regAddr, `ADDR_STOP_METHOD, 0)) rdData = 32'(stopMethod);
		for (int i = 0; i < 6; i++) begin
			if (wordAt(regAddr, `ADDR_IN_FUNC_BASE, i)) rdData = 32'(inSel[i]);
		end
		if (wordAt(regAddr, `ADDR_INIT_MODE, 0)) rdData = 32'(initMode);
		if (wordAt(regAddr, `ADDR_MIN_BLOCK, 0)) rdData = 32'(minBlock);
		for (int i = 0; i < 8; i++) begin
			if (wordAt(regAddr, `ADDR_RAMP_TIME_BASE, i)) rdData = 32'(rampTime[i]);
		end
		if (wordAt(regAddr, `ADDR_STATUS, 0)) begin
			rdData = {24'h000000, revRejected, runIgnored, threeWire, rampPair, state};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			swFreq     <= `RAMP_SW_FREQ_RST;
			revInhibit <= 1'b0;
			stopMethod <= `STOP_RAMP;
			inSel      <= {`SEL_RST5, `SEL_RST4, `SEL_RST3, `SEL_RST2, `SEL_RST1, `SEL_RST0};
			initMode   <= 16'h0000;
			minBlock   <= `MIN_BLOCK_RST;
			rampTime   <= {8{`RAMP_TIME_RST}};
			state      <= ST_IDLE;
			dirRev     <= 1'b0;
			latch3w    <= 1'b0;
			fastHold   <= 1'b0;
		end else begin
			swFreq     <= next_swFreq;
			revInhibit <= next_revInhibit;
			stopMethod <= next_stopMethod;
			inSel      <= next_inSel;
			initMode   <= next_initMode;
			minBlock   <= next_minBlock;
			rampTime   <= next_rampTime;
			state      <= next_state;
			dirRev     <= next_dirRev;
			latch3w    <= next_latch3w;
			fastHold   <= next_fastHold;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rampPair    <= `PAIR_ONE;
			accelTime   <= `RAMP_TIME_RST;
			decelTime   <= `RAMP_TIME_RST;
			runFwd      <= 1'b0;
			runRev      <= 1'b0;
			rampDown    <= 1'b0;
			coasting    <= 1'b0;
			dcBrake     <= 1'b0;
			runIgnored  <= 1'b0;
			threeWire   <= 1'b0;
			revRejected <= 1'b0;
			fastStop    <= 1'b0;
			stepRef     <= 3'h0;
			jogRef      <= 1'b0;
			analogSel   <= 1'b0;
		end else begin
			rampPair    <= pairNow;
			accelTime   <= rampTime[{pairNow, 1'b0}];
			decelTime   <= rampTime[{pairNow, 1'b1}];
			runFwd      <= next_state == ST_RUN && !next_dirRev;
			runRev      <= next_state == ST_RUN && next_dirRev;
			rampDown    <= next_state == ST_RAMP;
			coasting    <= next_state == ST_COAST || next_state == ST_COAST_T;
			dcBrake     <= next_state == ST_DC;
			runIgnored  <= (next_state == ST_COAST || next_state == ST_COAST_T) && rawRun;
			threeWire   <= is3w;
			revRejected <= revBlock;
			fastStop    <= fastNow | fastHold;
			stepRef     <= {anyOn(inSel, termIn, `FUNC_STEP3), anyOn(inSel, termIn, `FUNC_STEP2),
				anyOn(inSel, termIn, `FUNC_STEP1)};
			jogRef      <= anyOn(inSel, termIn, `FUNC_JOG_REF);
			analogSel   <= anyOn(inSel, termIn, `FUNC_ANALOG_SW);
		end
	end
endmodule : drive_ramp_stop_input_select

`default_nettype wire

// File: dv/drive_ramp_stop_input_select_properties.sv
`default_nettype none

module drive_ramp_stop_input_select_properties #(
	parameter int TENTH_CYCLES = 4
) (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [5:0]  termIn,
	input wire logic        fwdRunIn,
	input wire logic        revRunIn,
	input wire logic [12:0] outFreq,
	input wire logic        runFwd,
	input wire logic        runRev,
	input wire logic        rampDown,
	input wire logic        coasting,
	input wire logic        dcBrake,
	input wire logic        runIgnored,
	input wire logic        threeWire,
	input wire logic        revRejected
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] coastLen;
	logic [31:0] next_coastLen;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence readAnswer;
		!hreadyout ##1 hreadyout;
	endsequence
	always_comb next_coastLen = coasting ? coastLen + 32'h1 : 32'h0;
	always_ff @(posedge clk_sys) coastLen <= rst_b ? next_coastLen : 32'h0;
	a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> readAnswer)
		else $error("read answer not after one wait");
	a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_rev_block: assert property (revRejected |-> !runRev)
		else $error("reverse ran while rejected");
	a_run_ignored: assert property (runIgnored |-> !runFwd && !runRev)
		else $error("run taken during lockout");
	a_one_mode: assert property ($onehot0({runFwd, runRev, rampDown, coasting, dcBrake}))
		else $error("two motion modes at once");
	a_coast_min: assert property ($fell(coasting) |-> coastLen >= TENTH_CYCLES)
		else $error("coast lockout too short");
	a_ramp_ends: assert property (rampDown && outFreq == 13'h0 |-> ##[1:2] !rampDown)
		else $error("ramp stop did not end");
	a_no_cmd_stop: assert property (!threeWire && !fwdRunIn && !revRunIn && termIn == 6'h0
		|=> !runFwd && !runRev)
		else $error("running without command");
endmodule : drive_ramp_stop_input_select_properties

`default_nettype wire

// File: dv/drive_motor_stage.sv
`default_nettype none

// Output stage: follows the commanded speed, slows freely when not driven
module drive_motor_stage (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        runFwd,
	input  wire logic        runRev,
	input  wire logic        manual,
	input  wire logic [12:0] target,
	output var  logic [12:0] outFreq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [12:0] next_outFreq;
	always_comb begin
		if (manual || runFwd || runRev)
			next_outFreq = target;
		else if (outFreq > 13'h010)
			next_outFreq = outFreq - 13'h010;
		else
			next_outFreq = 13'h000;
	end
	always_ff @(posedge clk_sys) outFreq <= rst_b ? next_outFreq : 13'h000;
endmodule : drive_motor_stage

`default_nettype wire

// File: dv/drive_ramp_stop_input_select_tb.sv
`default_nettype none

module drive_ramp_stop_input_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, rst_b, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, rampPair;
	logic [2:0]  hsize, stepRef;
	logic [5:0]  termIn;
	logic        fwdRunIn, revRunIn, fluxVector, manual;
	logic [12:0] outFreq, target;
	logic [15:0] accelTime, decelTime, rnd;
	logic        runFwd, runRev, rampDown, coasting, dcBrake;
	logic        runIgnored, threeWire, revRejected, fastStop, jogRef, analogSel;
	int          err_count, cmp_count, busy, n, t, i;
	int          mdl[19];

	drive_ramp_stop_input_select #(.TENTH_CYCLES(4)) dut (.clk_sys, .rst_b, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.termIn, .fwdRunIn, .revRunIn, .fluxVector, .outFreq, .rampPair, .accelTime,
		.decelTime, .runFwd, .runRev, .rampDown, .coasting, .dcBrake, .runIgnored,
		.threeWire, .revRejected, .fastStop, .stepRef, .jogRef, .analogSel);
	drive_motor_stage motor (.clk_sys, .rst_b, .runFwd, .runRev, .manual, .target, .outFreq);

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	function automatic logic [15:0] nextRand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nextRand

	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Holds each phase until hready is seen at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : bus

	// Model: range, run lock and mode checks on each setting write
	function automatic void mwr(input int x, input logic [31:0] d);
		int lim;
		lim = x == 0 ? 'hfa0 : x == 1 ? 1 : x == 2 ? 3 : x < 9 ? 'h77 : x < 11 ? 'hffff : 'hea60;
		if (x > 18 || d > lim || (busy != 0 && (x < 11 || x > 14)))
			return;
		if (x == 2 && fluxVector && d > 1)
			return;
		mdl[x] = d;
		if (x == 9 && d == 'hd02) begin
			mdl[5] = 0;
			mdl[6] = 3;
			mdl[7] = 4;
			mdl[8] = 6;
		end
	endfunction : mwr

	task automatic tw(input int a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, 8'(a), d, r);
		mwr(a / 4, d);
	endtask : tw

	task automatic trd(input int a);
		logic [31:0] r;
		bus(1'b0, 8'(a), 32'h0, r);
		chk(r, a < 'h4c ? 32'(mdl[a / 4]) : 32'h0);
	endtask : trd

	// Run, stop, then ask to run again inside the lockout
	task automatic coastRun(input int lo);
		fwdRunIn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		fwdRunIn <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
			if (n == 4) fwdRunIn <= 1'b1;
			if (n == 6) chk({runIgnored, runFwd}, 2'b10);
		end while ((n < 3 || coasting === 1'b1) && n < 60);
		chk(32'(n >= lo && n <= lo + 8), 1);
		fwdRunIn <= 1'b0;
		repeat (40) @(posedge clk_sys);
	endtask : coastRun

	task automatic doReset;
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		busy = 0;
		mdl = '{0, 0, 0, 'h24, 'h14, 3, 4, 6, 8, 0, 5,
			'h64, 'h64, 'h64, 'h64, 'h64, 'h64, 'h64, 'h64};
		@(posedge clk_sys);
	endtask : doReset

	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, termIn} = '0;
		{fwdRunIn, revRunIn, fluxVector, rst_b, target} = '0;
		hsize = 3'h2;
		manual = 1'b1;
		rnd = 16'h2683;
		doReset();
		for (int a = 0; a < 'h54; a += 4)
			if (a != 'h4c) trd(a);
		for (int k = 0; k < 24; k++) begin
			rnd = nextRand(rnd);
			i = rnd % 21;
			fluxVector <= rnd[5];
			tw(i * 4, {16'h0, nextRand(rnd)} >> rnd[3:0]);
			if (i != 19) trd(i * 4);
		end
		doReset();
		for (int k = 0; k < 8; k++)
			tw('h2c + 4 * k, 'h100 + k);
		rnd = nextRand(rnd);
		t = rnd % 'hfa0 + 1;
		tw(0, t);
		target <= 13'(t);
		repeat (3) @(posedge clk_sys);
		chk(rampPair, 0);
		chk(decelTime, mdl[12]);
		target <= 13'(t - 1);
		repeat (3) @(posedge clk_sys);
		chk(rampPair, 3);
		chk(accelTime, mdl[17]);
		tw('h0c, 'h7);
		tw('h10, 'h1a);
		for (int k = 0; k < 4; k++) begin
			termIn <= 6'(k);
			repeat (3) @(posedge clk_sys);
			chk(rampPair, k);
			chk(decelTime, mdl[12 + 2 * k]);
		end
		termIn <= 6'h0;
		tw(4, 1);
		revRunIn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({revRejected, runRev}, 2'b10);
		bus(1'b0, 8'h4c, 32'h0, rd);
		chk(rd, 32'h80);
		revRunIn <= 1'b0;
		fluxVector <= 1'b1;
		tw(8, 2);
		trd(8);
		fluxVector <= 1'b0;
		tw('h28, 2);
		manual <= 1'b0;
		target <= 13'h64;
		fwdRunIn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(runFwd, 1);
		busy = 1;
		tw(0, 5);
		trd(0);
		tw('h2c, 'h77);
		trd('h2c);
		fwdRunIn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(rampDown, 1);
		chk(decelTime, mdl[12]);
		repeat (20) @(posedge clk_sys);
		busy = 0;
		tw(8, 1);
		coastRun(8);
		tw(8, 2);
		fwdRunIn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		fwdRunIn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk(dcBrake, 1);
		repeat (20) @(posedge clk_sys);
		chk(dcBrake, 0);
		tw('h30, 3);
		tw(8, 3);
		coastRun(12);
		tw('h0c, 'h15);
		fwdRunIn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		termIn <= 6'h01;
		repeat (2) @(posedge clk_sys);
		chk({fastStop, rampDown}, 2'b11);
		termIn <= 6'h00;
		repeat (2) @(posedge clk_sys);
		chk({fastStop, runFwd}, 2'b10);
		fwdRunIn <= 1'b0;
		repeat (20) @(posedge clk_sys);
		tw('h0c, 'h05);
		tw('h10, 'h1f);
		rnd = nextRand(rnd);
		termIn <= rnd[5:0];
		repeat (3) @(posedge clk_sys);
		chk({stepRef, jogRef, analogSel}, {rnd[0], rnd[3], rnd[2], rnd[4], rnd[1]});
		termIn <= 6'h04;
		tw(4, 0);
		tw('h24, 'hd02);
		for (int a = 'h14; a < 'h24; a += 4)
			trd(a);
		repeat (2) @(posedge clk_sys);
		chk(threeWire, 1);
		revRunIn <= 1'b1;
		fwdRunIn <= 1'b1;
		@(posedge clk_sys);
		fwdRunIn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk({runRev, runFwd}, 2'b10);
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		finish_test();
	end
endmodule : drive_ramp_stop_input_select_tb

bind drive_ramp_stop_input_select drive_ramp_stop_input_select_properties #(
	.TENTH_CYCLES(TENTH_CYCLES)
) props (.*);

`default_nettype wire
